// *** src/fdmc_defines.vh ***
// Constants for the flash driver mode controller
`ifndef FDMC_DEFINES_VH
`define FDMC_DEFINES_VH
// Register offsets
`define FDMC_ADDR_TORCH     8'hA0
`define FDMC_ADDR_FLASH     8'hB0
`define FDMC_ADDR_CONFIG1   8'hC0
`define FDMC_ADDR_DURATION  8'hC1
`define FDMC_ADDR_PINCFG    8'hC2
`define FDMC_ADDR_FLAGS     8'hC3
`define FDMC_ADDR_STATUS    8'hC4
// Reset values
`define FDMC_RST_BYTE       8'h00
// Brightness register fields
`define FDMC_SRC_LO         0
`define FDMC_SRC_HI         1
`define FDMC_VM_BIT         2
`define FDMC_CODE_LO        3
`define FDMC_CODE_HI        5
// Configuration register 1 fields
`define FDMC_LLDIS_BIT      0
`define FDMC_OV_BIT         1
`define FDMC_TSD_BIT        2
// Duration register current limit field
`define FDMC_CL_LO          5
`define FDMC_CL_HI          6
// Pin configuration fields
`define FDMC_P1_LO          0
`define FDMC_P1_HI          1
`define FDMC_P2_LO          2
`define FDMC_P2_HI          3
`define FDMC_NTC_BIT        4
`define FDMC_GPO1_BIT       5
`define FDMC_GPO2_BIT       6
// Pin function codes
`define FDMC_PF_A           2'h0
`define FDMC_PF_B           2'h1
`define FDMC_PF_GPIO        2'h2
// Ramp step time, clock period and current code constants
`define FDMC_STEP_NS        16000
`define FDMC_CLK_NS         10
`define FDMC_CODE_W         3
`define FDMC_ZERO_CODE      3'h0
`endif

// *** src/fdmc_sync.v ***
// Two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module fdmc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         clkEn,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);
  reg [W-1:0] meta_q;   // First stage, read only by second
  reg [W-1:0] sync_q;   // Second stage
  // Shift through two stages
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (clkEn) begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end
  assign syncOut = sync_q;
endmodule

// *** src/fdmc_top.v ***
// Mode and sequencing controller of the LED flash driver
//
// What this block does
// - Turn on from brightness bits or pins
// - Bits 1:0 sources, bit 2 voltage mode
// - Strobe high forces flash mode
// - Voltage enable pin forces voltage mode
// - Sources off until precharge threshold
// - Ramp current codes, 16 us each
// - Choose boost or pass on headroom
// - Pass mode holds high switch on
// - LED switching keeps 300 mV headroom
// - Pass to switching latches until sequencer returns to off
// - Voltage mode regulates 4.5 or 5 V
// - Light load uses pulsed switching
// - Config bit zero disables light load
// - Light load forced off in LED mode
// - Disabled light load means fixed frequency
// - Pin two: voltage enable, interrupt, GPIO
// - Pin one: interrupt, torch enable, GPIO
// - Shutdown pin low stops whole device
// - Indicator pin: driver or thermal input
// - Thermal trip drops flash to torch/off
// - Five readable fault flags
// - Config bit one selects 5 V level
// - Duration bits 6:5 pick current limit
// - Overvoltage stops switching, not pass mode, until recovery
`timescale 1ns/10ps
`include "fdmc_defines.vh"
module fdmc_top #(
  parameter STEP_NS = `FDMC_STEP_NS
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       clkEn,
  input  wire       hardware_shutdown_n,
  input  wire       strobePin,
  input  wire       pinOneIn,
  output reg        pinOneOut,
  output reg        pinOneOe,
  input  wire       pinTwoIn,
  output reg        pinTwoOut,
  output reg        pinTwoOe,
  input  wire       outAboveEnable,
  input  wire       outNearInput,
  input  wire       headroomLow,
  input  wire       thermalTrip,
  input  wire       overVoltTrip,
  input  wire       overVoltRecovered,
  input  wire       currentLimitHit,
  input  wire [4:0] faultEvents,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  output reg  [7:0] regRdata,
  output reg        srcEnA,
  output reg        srcEnB,
  output reg        indicatorEn,
  output reg  [2:0] ledCode,
  output reg        precharge,
  output reg        passMode,
  output reg        switchEn,
  output reg        voltMode,
  output reg        outputLevel5v,
  output reg        lightLoadEn,
  output reg  [1:0] currentLimitSel
);
  // Ramp step length in clock cycles, rounded up
  localparam integer STEP_CYC = (STEP_NS + `FDMC_CLK_NS - 1) / `FDMC_CLK_NS;
  localparam [1:0] ST_OFF  = 2'h0;  // Device off
  localparam [1:0] ST_PRE  = 2'h1;  // Precharging output
  localparam [1:0] ST_RAMP = 2'h2;  // Stepping current up
  localparam [1:0] ST_RUN  = 2'h3;  // At target

  // Synchronised pins and comparators
  wire [10:0] syncBus;
  wire        shutN;          // Shutdown pin, synchronised
  wire        strobe;         // Strobe pin
  wire        pinOne;         // Multi-function pin one
  wire        pinTwo;         // Multi-function pin two
  wire        cmpAbove;       // Output above enable threshold
  wire        cmpNear;        // Output near input
  wire        cmpHrLow;       // Headroom below minimum
  wire        cmpTherm;       // Thermal pin below trip
  wire        cmpOv;          // Overvoltage tripped
  wire        cmpOvRec;       // Output below recovery level
  wire        cmpIlim;        // Switch current limit reached

  fdmc_sync #(
    .W (11)
  ) uSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .asyncIn ({hardware_shutdown_n, strobePin, pinOneIn, pinTwoIn,
               outAboveEnable, outNearInput, headroomLow, thermalTrip,
               overVoltTrip, overVoltRecovered, currentLimitHit}),
    .syncOut (syncBus)
  );
  assign {shutN, strobe, pinOne, pinTwo, cmpAbove, cmpNear, cmpHrLow,
          cmpTherm, cmpOv, cmpOvRec, cmpIlim} = syncBus;

  // Software registers
  reg [7:0]  torch_q;         // Torch brightness control
  reg [7:0]  flash_q;         // Flash brightness control
  reg [7:0]  config1_q;       // Configuration register 1
  reg [7:0]  duration_q;      // Flash duration register
  reg [7:0]  pinCfg_q;        // Pin function configuration
  reg [4:0]  flags_q;         // Sticky fault flags
  // Sequencer state
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [15:0] stepCnt_q;       // Cycles within a ramp step
  reg [2:0]  code_q;          // Current code being driven
  reg        boostLatch_q;    // Switching decision latched
  reg        decided_q;       // Pass or boost decided
  reg        ovHold_q;        // Overvoltage hold-off
  reg        ilimHold_q;      // Current limit in this cycle

  // Pin function decode
  wire [1:0] p1Fn = pinCfg_q[`FDMC_P1_HI:`FDMC_P1_LO];
  wire [1:0] p2Fn = pinCfg_q[`FDMC_P2_HI:`FDMC_P2_LO];
  wire       ntcMode = pinCfg_q[`FDMC_NTC_BIT];
  wire       txOne    = (p1Fn == `FDMC_PF_A) && pinOne;
  wire       hwTorch  = (p1Fn == `FDMC_PF_B) && pinOne;
  wire       voltage_mode_enable_pin     = (p2Fn == `FDMC_PF_A) && pinTwo;
  wire       txTwo    = (p2Fn == `FDMC_PF_B) && pinTwo;
  // thermal trip only in sense mode
  wire       ntcTrip  = ntcMode && cmpTherm;
  wire       ntcOff   = ntcTrip && config1_q[`FDMC_TSD_BIT];

  wire [1:0] torchSrc = torch_q[`FDMC_SRC_HI:`FDMC_SRC_LO];
  wire [1:0] flashSrc = flash_q[`FDMC_SRC_HI:`FDMC_SRC_LO];
  wire       flashReq = (|flashSrc) || strobe;       // strobe
  wire       torchReq = (|torchSrc) || hwTorch;
  wire       vmReq    = torch_q[`FDMC_VM_BIT] || flash_q[`FDMC_VM_BIT]
                        || voltage_mode_enable_pin;
  // any source turns the device on unless the thermal trip shuts it off
  wire       anyOn    = (flashReq || torchReq || vmReq) && !ntcOff;
  // Flash falls back to torch on interrupts or thermal trip
  wire       useFlash = flashReq && !txOne && !txTwo && !ntcTrip;
  wire [2:0] target   = useFlash ?
                        flash_q[`FDMC_CODE_HI:`FDMC_CODE_LO] :
                        torch_q[`FDMC_CODE_HI:`FDMC_CODE_LO];
  wire [1:0] srcSel   = useFlash ? flashSrc :
                        ((|torchSrc) ? torchSrc : 2'h3);
  wire       ledOn    = (flashReq || torchReq) && !ntcOff;

  // Step timer done
  wire       stepDone = (stepCnt_q == STEP_CYC[15:0] - 16'h0001);

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (anyOn) begin
          state_d = ST_PRE;
        end
      end
      ST_PRE: begin
        if (!anyOn) begin
          state_d = ST_OFF;
        end else if (cmpAbove) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (!anyOn) begin
          state_d = ST_OFF;
        end else if (code_q >= target) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!anyOn) begin
          state_d = ST_OFF;
        end else if (code_q < target) begin
          state_d = ST_RAMP;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // Sequencer registers and conversion mode
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ST_OFF;
      stepCnt_q    <= 16'h0000;
      code_q       <= `FDMC_ZERO_CODE;
      boostLatch_q <= 1'b0;
      decided_q    <= 1'b0;
      ovHold_q     <= 1'b0;
      ilimHold_q   <= 1'b0;
    end else if (clkEn) begin
      if (!shutN) begin
        state_q      <= ST_OFF;
        stepCnt_q    <= 16'h0000;
        code_q       <= `FDMC_ZERO_CODE;
        boostLatch_q <= 1'b0;
        decided_q    <= 1'b0;
        ovHold_q     <= 1'b0;
        ilimHold_q   <= 1'b0;
      end else begin
        state_q <= state_d;
        // Step timer runs only while ramping
        if (state_q == ST_RAMP && !stepDone) begin
          stepCnt_q <= stepCnt_q + 16'h0001;
        end else begin
          stepCnt_q <= 16'h0000;
        end
        // Code stepping; lower target applies at once
        if (state_q == ST_OFF || state_q == ST_PRE) begin
          code_q <= `FDMC_ZERO_CODE;
        end else if (code_q > target) begin
          code_q <= target;
        end else if (state_q == ST_RAMP && stepDone && code_q < target) begin
          code_q <= code_q + 3'h1;
        end
        if (state_q == ST_OFF) begin
          decided_q    <= 1'b0;
          boostLatch_q <= 1'b0;
        end else if (!decided_q && cmpNear) begin
          decided_q    <= 1'b1;
          boostLatch_q <= cmpHrLow || vmReq;
        end else if (decided_q && cmpHrLow) begin
          boostLatch_q <= 1'b1;
        end
        if (cmpOv) begin
          ovHold_q <= 1'b1;
        end else if (cmpOvRec) begin
          ovHold_q <= 1'b0;
        end
        // current limit ends switching in cycle
        ilimHold_q <= cmpIlim;
      end
    end
  end

  // Software register writes and flags
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      torch_q    <= `FDMC_RST_BYTE;
      flash_q    <= `FDMC_RST_BYTE;
      config1_q  <= `FDMC_RST_BYTE;
      duration_q <= `FDMC_RST_BYTE;
      pinCfg_q   <= `FDMC_RST_BYTE;
      flags_q    <= 5'h00;
    end else if (clkEn) begin
      if (!shutN) begin
        // Shutdown returns registers to defaults
        torch_q    <= `FDMC_RST_BYTE;
        flash_q    <= `FDMC_RST_BYTE;
        config1_q  <= `FDMC_RST_BYTE;
        duration_q <= `FDMC_RST_BYTE;
        pinCfg_q   <= `FDMC_RST_BYTE;
        flags_q    <= 5'h00;
      end else begin
        if (regWrite) begin
          case (regAddr)
            `FDMC_ADDR_TORCH:    torch_q    <= regWdata;
            `FDMC_ADDR_FLASH:    flash_q    <= regWdata;
            `FDMC_ADDR_CONFIG1:  config1_q  <= regWdata;
            `FDMC_ADDR_DURATION: duration_q <= regWdata;
            `FDMC_ADDR_PINCFG:   pinCfg_q   <= regWdata;
            default: begin
            end
          endcase
        end
        if (regRead && regAddr == `FDMC_ADDR_FLAGS) begin
          flags_q <= faultEvents;
        end else begin
          flags_q <= flags_q | faultEvents;
        end
      end
    end
  end

  // Registered outputs
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata        <= 8'h00;
      srcEnA          <= 1'b0;
      srcEnB          <= 1'b0;
      indicatorEn     <= 1'b0;
      ledCode         <= 3'h0;
      precharge       <= 1'b0;
      passMode        <= 1'b0;
      switchEn        <= 1'b0;
      voltMode        <= 1'b0;
      outputLevel5v   <= 1'b0;
      lightLoadEn     <= 1'b0;
      currentLimitSel <= 2'h0;
      pinOneOut       <= 1'b0;
      pinOneOe        <= 1'b0;
      pinTwoOut       <= 1'b0;
      pinTwoOe        <= 1'b0;
    end else if (clkEn) begin
      // Read data mux, unmapped reads zero
      case (regAddr)
        `FDMC_ADDR_TORCH:    regRdata <= torch_q;
        `FDMC_ADDR_FLASH:    regRdata <= flash_q;
        `FDMC_ADDR_CONFIG1:  regRdata <= config1_q;
        `FDMC_ADDR_DURATION: regRdata <= duration_q;
        `FDMC_ADDR_PINCFG:   regRdata <= pinCfg_q;
        `FDMC_ADDR_FLAGS:    regRdata <= {3'h0, flags_q};
        `FDMC_ADDR_STATUS:   regRdata <= {pinTwo, pinOne, boostLatch_q,
                                          decided_q, code_q[1:0], state_q};
        default:             regRdata <= 8'h00;
      endcase
      srcEnA      <= ledOn && state_q[1] && srcSel[0];
      srcEnB      <= ledOn && state_q[1] && srcSel[1];
      indicatorEn <= ledOn && state_q[1] && !ntcMode;
      ledCode     <= code_q;
      precharge   <= (state_q == ST_PRE);
      passMode    <= decided_q && !boostLatch_q && state_q != ST_OFF;
      switchEn    <= decided_q && boostLatch_q && state_q != ST_OFF
                     && !ovHold_q && !cmpOv && !ilimHold_q;
      voltMode      <= vmReq && state_q != ST_OFF;
      outputLevel5v <= config1_q[`FDMC_OV_BIT];
      lightLoadEn <= vmReq && state_q != ST_OFF && !ledOn
                     && !config1_q[`FDMC_LLDIS_BIT];
      currentLimitSel <= duration_q[`FDMC_CL_HI:`FDMC_CL_LO];
      // General purpose outputs when pins are GPIO
      pinOneOut <= pinCfg_q[`FDMC_GPO1_BIT];
      pinOneOe  <= (p1Fn == `FDMC_PF_GPIO) && pinCfg_q[`FDMC_GPO1_BIT];
      pinTwoOut <= pinCfg_q[`FDMC_GPO2_BIT];
      pinTwoOe  <= (p2Fn == `FDMC_PF_GPIO) && pinCfg_q[`FDMC_GPO2_BIT];
    end
  end
endmodule

// *** tb/fdmc_checker.sv ***
// Concurrent checks on the mode controller ports
`timescale 1ns/10ps
module fdmc_checker #(
  parameter STEP_NS = 16000
) (
  input wire       clk,
  input wire       rst_b,
  input wire       hardware_shutdown_n,
  input wire       overVoltTrip,
  input wire       srcEnA,
  input wire       srcEnB,
  input wire       indicatorEn,
  input wire [2:0] ledCode,
  input wire       precharge,
  input wire       passMode,
  input wire       switchEn,
  input wire       voltMode,
  input wire       lightLoadEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shutdown pin held low long enough to pass the synchroniser,
  // the sequencer and the output flip-flops
  sequence s_off5;
    !hardware_shutdown_n [*5];
  endsequence
  // Current code moved upward
  sequence s_step;
    ledCode > $past(ledCode);
  endsequence
  chk_pre_srcoff: assert property (
    precharge |-> !srcEnA && !srcEnB && !indicatorEn)
    else $error("current source on during precharge");
  chk_step_one: assert property (
    s_step |-> ledCode == $past(ledCode) + 3'h1)
    else $error("current code skipped a step");
  chk_step_hold: assert property (
    s_step |=> $stable(ledCode) [*8])
    else $error("current step held too briefly");
  chk_pass_nosw: assert property (
    passMode |-> !switchEn)
    else $error("switching while in pass mode");
  chk_ll_led: assert property (
    !voltMode && !$past(voltMode) |-> !lightLoadEn)
    else $error("light load active in LED mode");
  chk_sd_off: assert property (
    s_off5 |-> !srcEnA && !srcEnB && !switchEn && !precharge)
    else $error("device active during shutdown");
  chk_sd_clear: assert property (
    s_off5 |-> !passMode && ledCode == 3'h0)
    else $error("shutdown left mode or code set");
  chk_ovp_stop: assert property (
    overVoltTrip [*4] |-> !switchEn)
    else $error("switching during overvoltage");
endmodule

bind fdmc_top fdmc_checker #(.STEP_NS(STEP_NS)) i_chk (
  .clk(clk), .rst_b(rst_b), .hardware_shutdown_n(hardware_shutdown_n),
  .overVoltTrip(overVoltTrip), .srcEnA(srcEnA), .srcEnB(srcEnB),
  .indicatorEn(indicatorEn), .ledCode(ledCode), .precharge(precharge),
  .passMode(passMode), .switchEn(switchEn), .voltMode(voltMode),
  .lightLoadEn(lightLoadEn)
);

// *** tb/fdmc_cap_model.sv ***
// Output capacitor model answering the precharge current
`timescale 1ns/10ps
module fdmc_cap_model #(
  parameter CHARGE = 6
) (
  input  wire clk,
  input  wire shutN,
  input  wire precharge,
  output wire outAboveEnable,
  output wire outNearInput
);
  reg [3:0] chargeQ = 4'h0;  // Capacitor charge level, starts empty
  // Charge builds once precharge starts, lost at shutdown
  always @(posedge clk or negedge shutN) begin
    if (!shutN) begin
      chargeQ <= 4'h0;
    end else if ((precharge || chargeQ != 4'h0) && chargeQ != 4'hF) begin
      chargeQ <= chargeQ + 4'h1;
    end
  end
  // Enable threshold first, near-input level two cycles later
  assign outAboveEnable = (chargeQ >= CHARGE);
  assign outNearInput   = (chargeQ >= CHARGE + 2);
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the mode controller
`timescale 1ns/10ps
`include "fdmc_defines.vh"
module tb_top;
  reg        clk, rstB, shutN, strobe, headLow, ovTrip, ovRec;
  reg        p1In, therm;  // Pin one level, thermal comparator
  reg        wrEn, rdEn;
  reg  [4:0] faults;
  reg  [7:0] addr, wdata;
  wire [7:0] rdata;
  wire [2:0] code;
  wire [1:0] clSel;
  wire       srcEnA, srcEnB, indEn, pre, pass, swEn, vMode, lvl5, llEn;
  wire       p1Out, p1Oe, p2Out, p2Oe, aboveEn, nearIn;
  wire [3:0] flags = {swEn, pass, srcEnA, pre};  // Polled flags
  integer    mismatches, n_compared, i;

  fdmc_top #(.STEP_NS(100)) i_dut (
    .clk(clk), .rst_b(rstB), .clkEn(1'b1), .hardware_shutdown_n(shutN),
    .strobePin(strobe), .pinOneIn(p1In), .pinOneOut(p1Out),
    .pinOneOe(p1Oe), .pinTwoIn(1'b0), .pinTwoOut(p2Out), .pinTwoOe(p2Oe),
    .outAboveEnable(aboveEn), .outNearInput(nearIn),
    .headroomLow(headLow), .thermalTrip(therm), .overVoltTrip(ovTrip),
    .overVoltRecovered(ovRec), .currentLimitHit(1'b0),
    .faultEvents(faults), .regWrite(wrEn), .regRead(rdEn),
    .regAddr(addr), .regWdata(wdata), .regRdata(rdata),
    .srcEnA(srcEnA), .srcEnB(srcEnB), .indicatorEn(indEn),
    .ledCode(code), .precharge(pre), .passMode(pass), .switchEn(swEn),
    .voltMode(vMode), .outputLevel5v(lvl5), .lightLoadEn(llEn),
    .currentLimitSel(clSel));
  fdmc_cap_model i_cap (.clk(clk), .shutN(shutN), .precharge(pre),
    .outAboveEnable(aboveEn), .outNearInput(nearIn));

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task check(input [95:0] name, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // One register write cycle
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      wrEn = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wrEn = 1'b0;
    end
  endtask
  // Read cycle, data settles one edge after the address
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk);
      rdEn = 1'b1;
      addr = a;
      @(negedge clk);
      rdEn = 1'b0;
      check("regRdata", rdata, e);
    end
  endtask
  // Bounded wait for a polled flag, then compare it
  task waitf(input integer k, input v);
    integer n;
    begin
      n = 0;
      while (flags[k] !== v && n < 300) begin
        @(negedge clk);
        n = n + 1;
      end
      check("flag", {7'h0, flags[k]}, {7'h0, v});
    end
  endtask
  // Shutdown pulse through the pin
  task shut;
    begin
      @(negedge clk);
      shutN = 1'b0;
      repeat (5) @(negedge clk);
      shutN = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
  // Counts, then the verdict
  task print_verdict;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    #300000;
    mismatches = mismatches + 1;
    print_verdict;
  end
  // Main sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    {rstB, shutN, strobe, headLow, ovTrip, wrEn, rdEn} = 7'h00;
    {p1In, therm} = 2'h0;
    ovRec = 1'b1;
    faults = 5'h00;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (5) @(negedge clk);
    rstB = 1'b1;
    shutN = 1'b1;
    repeat (4) @(negedge clk);
    rd(`FDMC_ADDR_TORCH, 8'h00);
    rd(`FDMC_ADDR_FLASH, 8'h00);
    rd(`FDMC_ADDR_CONFIG1, 8'h00);
    rd(8'h55, 8'h00);
    wr(`FDMC_ADDR_TORCH, 8'h1B);
    rd(`FDMC_ADDR_TORCH, 8'h1B);
    waitf(0, 1'b1);
    waitf(1, 1'b1);
    repeat (60) @(negedge clk);
    check("ledCode", {5'h0, code}, 8'h03);
    check("srcEnB", {7'h0, srcEnB}, 8'h01);
    waitf(2, 1'b1);
    headLow = 1'b1;
    waitf(3, 1'b1);
    headLow = 1'b0;
    repeat (10) @(negedge clk);
    check("latch", {6'h0, pass, swEn}, 8'h01);
    ovRec = 1'b0;
    ovTrip = 1'b1;
    repeat (6) @(negedge clk);
    check("ovpStop", {7'h0, swEn}, 8'h00);
    ovTrip = 1'b0;
    ovRec = 1'b1;
    waitf(3, 1'b1);
    shut;
    check("srcEnA", {7'h0, srcEnA}, 8'h00);
    rd(`FDMC_ADDR_TORCH, 8'h00);
    wr(`FDMC_ADDR_TORCH, 8'h1B);
    waitf(2, 1'b1);
    wr(`FDMC_ADDR_CONFIG1, 8'h02);
    wr(`FDMC_ADDR_TORCH, 8'h04);
    repeat (20) @(negedge clk);
    check("vMode", {5'h0, vMode, lvl5, llEn}, 8'h07);
    wr(`FDMC_ADDR_CONFIG1, 8'h03);
    repeat (4) @(negedge clk);
    check("llDis", {7'h0, llEn}, 8'h00);
    wr(`FDMC_ADDR_TORCH, 8'h03);
    repeat (4) @(negedge clk);
    check("ledMode", {6'h0, vMode, llEn}, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`FDMC_ADDR_DURATION, {1'b0, i[1:0], 5'h00});
      repeat (3) @(negedge clk);
      check("clSel", {6'h0, clSel}, {6'h0, i[1:0]});
    end
    wr(`FDMC_ADDR_PINCFG, 8'h2A);
    repeat (3) @(negedge clk);
    check("gpio", {4'h0, p1Oe, p1Out, p2Oe, p2Out}, 8'h0C);
    for (i = 0; i < 5; i = i + 1) begin
      @(negedge clk);
      faults = 5'h01 << i;
      @(negedge clk);
      faults = 5'h00;
      rd(`FDMC_ADDR_FLAGS, 8'h01 << i);
      rd(`FDMC_ADDR_FLAGS, 8'h00);
    end
    shut;
    strobe = 1'b1;
    waitf(0, 1'b1);
    // Strobe flash at code 4, torch fallback at code 1
    wr(`FDMC_ADDR_FLASH, 8'h23);
    wr(`FDMC_ADDR_TORCH, 8'h0B);
    repeat (80) @(negedge clk);
    check("flashCode", {5'h0, code}, 8'h04);
    check("indEn", {7'h0, indEn}, 8'h01);
    // Pin one as flash interrupt drops to torch code
    p1In = 1'b1;
    repeat (6) @(negedge clk);
    check("txOne", {5'h0, code}, 8'h01);
    p1In = 1'b0;
    repeat (60) @(negedge clk);
    check("reRamp", {5'h0, code}, 8'h04);
    // Thermal sense mode: trip drops to torch, then shuts down
    wr(`FDMC_ADDR_PINCFG, 8'h10);
    therm = 1'b1;
    repeat (6) @(negedge clk);
    check("ntcTorch", {5'h0, code}, 8'h01);
    check("indOff", {7'h0, indEn}, 8'h00);
    wr(`FDMC_ADDR_CONFIG1, 8'h04);
    repeat (4) @(negedge clk);
    check("ntcOff", {7'h0, srcEnA}, 8'h00);
    strobe = 1'b0;
    therm = 1'b0;
    print_verdict;
  end
endmodule
